// [current_feed.sv]
// Linefeed current source: one sample every eight clocks
module current_feed (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Current level to present
  input  wire logic signed [15:0] q1Level,
  // Sample stream
  output logic                    sampleValid,
  output logic signed      [15:0] currentQ1,
  output logic signed      [15:0] otherQ
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div;
  // Between samples the lines carry junk so stale values are never used
  always_ff @(posedge clk) begin
    div         <= reset ? 3'h0 : div + 3'h1;
    sampleValid <= !reset && div == 3'h7;
    currentQ1   <= (div == 3'h7) ? q1Level : ~currentQ1;
    otherQ      <= (div == 3'h7) ? 16'h0000 : ~otherQ;
  end
endmodule

// [detect_path.sv]
// Low-pass filter, hysteresis comparator and debounce for one current
module detect_path
  import loop_detect_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Sample stream
  input  wire logic               sampleValid,
  input  wire logic signed [15:0] sampleIn,
  // Settings
  input  wire logic        [15:0] coef,
  input  wire logic        [15:0] setThreshold,
  input  wire logic        [15:0] clearThreshold,
  input  wire logic               enable,
  input  wire logic        [15:0] interval,
  // Timing and masking
  input  wire logic               stepTick,
  input  wire logic               hold,
  // Results
  output logic signed      [15:0] filtered_q,
  output logic                    detected_q
);

  logic        [15:0] coefEff;
  logic signed [16:0] diff;
  logic signed [33:0] product;
  logic signed [16:0] sumNext;
  logic signed [16:0] level;
  logic               compare;
  logic        [15:0] stepCount_q;
  logic        [16:0] stepsNext;
  logic               expired;

  // ---------------------------------------------------------------
  // First-order low-pass: y += coef * (x - y) / unity
  // ---------------------------------------------------------------
  // Low three coefficient bits are not part of the field; values
  // above unity are clamped so the filter cannot overshoot.
  always_comb begin
    coefEff = {coef[15:3], 3'h0};
    if (coefEff > COEF_UNITY) begin
      coefEff = COEF_UNITY;
    end
  end

  assign diff    = {sampleIn[15], sampleIn} - {filtered_q[15], filtered_q};
  assign product = diff * $signed({1'b0, coefEff});
  assign sumNext = {filtered_q[15], filtered_q}
                 + product[COEF_FRAC_BITS+16:COEF_FRAC_BITS];

  always_ff @(posedge clk) begin
    if (reset) begin
      filtered_q <= 16'sh0000;
    end else if (sampleValid) begin
      filtered_q <= sumNext[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Hysteresis comparator
  // ---------------------------------------------------------------
  assign level = {filtered_q[15], filtered_q};

  always_comb begin
    if (!enable) begin
      compare = 1'b0;
    end else if (detected_q) begin
      compare = level >= $signed({1'b0, clearThreshold});
    end else begin
      compare = level > $signed({1'b0, setThreshold});
    end
  end

  // ---------------------------------------------------------------
  // Debounce
  // ---------------------------------------------------------------
  assign stepsNext = {1'b0, stepCount_q} + 17'h00001;
  assign expired   = stepsNext >= {1'b0, interval};

  always_ff @(posedge clk) begin
    if (reset) begin
      stepCount_q <= 16'h0000;
    end else if (compare == detected_q || hold) begin
      stepCount_q <= 16'h0000;
    end else if (stepTick && stepCount_q != 16'hFFFF) begin
      stepCount_q <= stepsNext[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      detected_q <= 1'b0;
    end else if (compare != detected_q && !hold && stepTick && expired) begin
      detected_q <= compare;
    end
  end

endmodule

// [loop_detect_pkg.sv]
// Constants shared by the loop-closure and ground-key detector
package loop_detect_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 100;
  localparam int DEBOUNCE_STEP_NS     = 1250000;
  localparam int DEBOUNCE_STEP_CYCLES = DEBOUNCE_STEP_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Register offsets (word index on the register port)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_LINEFEED      = 8'h00;
  localparam logic [7:0] OFS_DETECT_STATUS = 8'h01;
  localparam logic [7:0] OFS_IRQ_PENDING   = 8'h02;
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h03;
  localparam logic [7:0] OFS_LOOP_CURRENT  = 8'h04;
  localparam logic [7:0] OFS_LONG_CURRENT  = 8'h05;
  localparam logic [7:0] OFS_LOOP_LPF      = 8'h06;
  localparam logic [7:0] OFS_LOOP_OFFHK    = 8'h07;
  localparam logic [7:0] OFS_LOOP_ONHK     = 8'h08;
  localparam logic [7:0] OFS_LOOP_DBI      = 8'h09;
  localparam logic [7:0] OFS_LOOP_MASK     = 8'h0A;
  localparam logic [7:0] OFS_GKEY_LPF      = 8'h0B;
  localparam logic [7:0] OFS_GKEY_HITH     = 8'h0C;
  localparam logic [7:0] OFS_GKEY_LOTH     = 8'h0D;
  localparam logic [7:0] OFS_GKEY_DBI      = 8'h0E;
  localparam logic [7:0] OFS_CM_THRESHOLD  = 8'h24;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LF_CTRL_LSB     = 0;
  localparam int LF_SHADOW_LSB   = 4;
  localparam int STAT_CMH_BIT    = 0;
  localparam int STAT_LOOP_BIT   = 1;
  localparam int STAT_GKEY_BIT   = 2;
  localparam int IRQ_LOOP_BIT    = 0;
  localparam int IRQ_GKEY_BIT    = 1;
  localparam int COEF_FRAC_BITS  = 14;

  // ---------------------------------------------------------------
  // Linefeed state codes
  // ---------------------------------------------------------------
  localparam logic [2:0] LF_OPEN       = 3'h0;
  localparam logic [2:0] LF_FWD_ACTIVE = 3'h1;
  localparam logic [2:0] LF_TIP_OPEN   = 3'h3;
  localparam logic [2:0] LF_REV_ACTIVE = 3'h5;
  localparam logic [2:0] LF_RING_OPEN  = 3'h7;

  // ---------------------------------------------------------------
  // Limits and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] COEF_UNITY        = 16'h4000;
  localparam logic [15:0] LOOP_THRESH_LIMIT = 16'h4CF0;
  localparam logic [15:0] RST_LPF           = 16'h0A10;
  localparam logic [15:0] RST_LOOP_OFFHK    = 16'h1000;
  localparam logic [15:0] RST_LOOP_ONHK     = 16'h0C00;
  localparam logic [15:0] RST_GKEY_HITH     = 16'h0800;
  localparam logic [15:0] RST_GKEY_LOTH     = 16'h0600;
  localparam logic [15:0] RST_INTERVAL      = 16'h0008;
  localparam logic [15:0] RST_CM_THRESHOLD  = 16'h2000;
  localparam logic [1:0]  RST_IRQ_ENABLE    = 2'h0;

endpackage

// [loop_detector.sv]
// Loop-closure and ground-key detection for one line channel
//
// Behaviour
// - Loop current is Q1-Q6+Q5-Q2 in open states, half of it otherwise.
// - Common-mode high in states 1 or 3 zeroes the Q1 term.
// - Common-mode high in states 5 or 7 zeroes the Q2 term.
// - Common-mode flag sets above its threshold; other terms still count.
// - Loop current is low-pass filtered; zero blocks, 4000h passes.
// - Off-hook threshold detects closure; on-hook threshold gives hysteresis.
// - Loop debounce flips only after opposite state held whole interval.
// - Satisfied debounce sets the read-only loop-closure flag.
// - Mask interval after a ringing burst suppresses loop transitions.
// - Either loop threshold above 61 mA disables loop detection.
// - Loop event sets pending bit, gated by loop interrupt enable.
// - Longitudinal current is produced only in tip-open or ring-open.
// - Longitudinal current is (Q1-Q6-Q5+Q2)/2.
// - Longitudinal current has its own low-pass filter and coefficient.
// - Ground-key high threshold detects; low threshold detects release.
// - Satisfied ground-key debounce sets the ground-key flag.
// - Loop flag rising moves tip-open to forward, ring-open to reverse.
// - Linefeed shadow shows 3 for tip-open and 1 for forward-active.
// - Ground-key event sets pending bit, gated by its enable.
module loop_detector
  import loop_detect_pkg::*;
#(
  parameter int STEP_CYCLES = DEBOUNCE_STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Transistor current samples
  input  wire logic               sampleValid,
  input  wire logic signed [15:0] currentQ1,
  input  wire logic signed [15:0] currentQ2,
  input  wire logic signed [15:0] currentQ5,
  input  wire logic signed [15:0] currentQ6,
  // Ringing burst end marker
  input  wire logic               ringBurstEnd,
  // Register port
  input  wire logic        [7:0]  regAddr,
  input  wire logic        [15:0] regWrData,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  output logic             [15:0] regRdData,
  // Status
  output logic             [2:0]  linefeedState,
  output logic                    loopClosureFlag,
  output logic                    groundKeyFlag,
  output logic                    commonModeHighFlag,
  output logic                    irqRequest
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic        [2:0]  lineState_q;
  logic        [15:0] loopLpf_q;
  logic        [15:0] loopOffHook_q;
  logic        [15:0] loopOnHook_q;
  logic        [15:0] loopDebounce_q;
  logic        [15:0] loopMask_q;
  logic        [15:0] gkeyLpf_q;
  logic        [15:0] gkeyHigh_q;
  logic        [15:0] gkeyLow_q;
  logic        [15:0] gkeyDebounce_q;
  logic        [15:0] cmThreshold_q;
  logic        [1:0]  irqPending_q;
  logic        [1:0]  irqEnable_q;
  logic        [15:0] rdData_q;
  logic signed [15:0] loopCurrent_q;
  logic signed [15:0] longCurrent_q;
  logic               cmHigh_q;
  logic               pathValid_q;
  logic        [31:0] tickCount_q;
  logic               stepTick;
  logic        [15:0] maskCount_q;
  logic               maskActive;
  logic               loopPrev_q;
  logic               gkeyPrev_q;
  logic               loopDetected;
  logic               gkeyDetected;
  logic signed [15:0] loopFiltered;
  logic signed [15:0] longFiltered;
  logic               openState;
  logic               dropQ1;
  logic               dropQ2;
  logic signed [17:0] termQ1;
  logic signed [17:0] termQ2;
  logic signed [17:0] loopSum;
  logic signed [17:0] longSum;
  logic signed [17:0] longHalf;
  logic        [17:0] longMagnitude;
  logic               loopEnable;
  logic               loopEvent;
  logic               gkeyEvent;
  logic               loopRise;
  logic               wrLinefeed;
  logic               wrPending;
  logic        [1:0]  eventBits;

  // Clamp an 18-bit intermediate into the 16-bit sample range
  function automatic logic signed [15:0] saturate(input logic signed [17:0] v);
    if (v > 18'sh07FFF) begin
      return 16'sh7FFF;
    end else if (v < -18'sh08000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction

  function automatic logic isOpenState(input logic [2:0] lf);
    return lf == LF_TIP_OPEN || lf == LF_RING_OPEN;
  endfunction

  // ---------------------------------------------------------------
  // Input signal processing
  // ---------------------------------------------------------------
  assign openState = isOpenState(lineState_q);
  assign dropQ1    = cmHigh_q && (lineState_q == LF_FWD_ACTIVE
                              || lineState_q == LF_TIP_OPEN);
  assign dropQ2    = cmHigh_q && (lineState_q == LF_REV_ACTIVE
                              || lineState_q == LF_RING_OPEN);
  assign termQ1    = dropQ1 ? 18'sh00000 : 18'(currentQ1);
  assign termQ2    = dropQ2 ? 18'sh00000 : 18'(currentQ2);

  // Only the conditioned terms are zeroed; Q5 and Q6 always count
  assign loopSum = termQ1 - 18'(currentQ6)
                 + 18'(currentQ5) - termQ2;

  // Common-mode measure uses raw terms so zeroing cannot hide it
  assign longSum  = 18'(currentQ1) - 18'(currentQ6)
                  - 18'(currentQ5) + 18'(currentQ2);
  assign longHalf = longSum >>> 1;
  assign longMagnitude = longHalf[17] ? 18'(-longHalf) : longHalf;

  always_ff @(posedge clk) begin
    if (reset) begin
      loopCurrent_q <= 16'sh0000;
    end else if (sampleValid) begin
      if (openState) begin
        loopCurrent_q <= saturate(loopSum);
      end else begin
        loopCurrent_q <= saturate(loopSum >>> 1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      longCurrent_q <= 16'sh0000;
    end else if (sampleValid) begin
      longCurrent_q <= openState ? saturate(longHalf)
                                 : 16'sh0000;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmHigh_q <= 1'b0;
    end else if (sampleValid) begin
      cmHigh_q <= longMagnitude > {2'h0, cmThreshold_q};
    end
  end

  // Filters see each processed sample one cycle after it is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      pathValid_q <= 1'b0;
    end else begin
      pathValid_q <= sampleValid;
    end
  end

  // ---------------------------------------------------------------
  // Debounce step timer and loop mask
  // ---------------------------------------------------------------
  assign stepTick = tickCount_q == 32'(STEP_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (reset || stepTick) begin
      tickCount_q <= 32'h00000000;
    end else begin
      tickCount_q <= tickCount_q + 32'h00000001;
    end
  end

  // A new burst end restarts the mask even if one is running
  always_ff @(posedge clk) begin
    if (reset) begin
      maskCount_q <= 16'h0000;
    end else if (ringBurstEnd) begin
      maskCount_q <= loopMask_q;
    end else if (stepTick && maskCount_q != 16'h0000) begin
      maskCount_q <= maskCount_q - 16'h0001;
    end
  end

  assign maskActive = maskCount_q != 16'h0000;

  // ---------------------------------------------------------------
  // Detection paths
  // ---------------------------------------------------------------
  assign loopEnable = loopOffHook_q <= LOOP_THRESH_LIMIT
                   && loopOnHook_q <= LOOP_THRESH_LIMIT;

  // Loop path: filter, hysteresis, debounce, masked after ringing
  detect_path loopPath (
    .clk            (clk),
    .reset          (reset),
    .sampleValid    (pathValid_q),
    .sampleIn       (loopCurrent_q),
    .coef           (loopLpf_q),
    .setThreshold   (loopOffHook_q),
    .clearThreshold (loopOnHook_q),
    .enable         (loopEnable),
    .interval       (loopDebounce_q),
    .stepTick       (stepTick),
    .hold           (maskActive),
    .filtered_q     (loopFiltered),
    .detected_q     (loopDetected)
  );

  detect_path gkeyPath (
    .clk            (clk),
    .reset          (reset),
    .sampleValid    (pathValid_q),
    .sampleIn       (longCurrent_q),
    .coef           (gkeyLpf_q),
    .setThreshold   (gkeyHigh_q),
    .clearThreshold (gkeyLow_q),
    .enable         (1'b1),
    .interval       (gkeyDebounce_q),
    .stepTick       (stepTick),
    .hold           (1'b0),
    .filtered_q     (longFiltered),
    .detected_q     (gkeyDetected)
  );

  // ---------------------------------------------------------------
  // Events and pending bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      loopPrev_q <= 1'b0;
      gkeyPrev_q <= 1'b0;
    end else begin
      loopPrev_q <= loopDetected;
      gkeyPrev_q <= gkeyDetected;
    end
  end

  // Either flag edge is an event: software sees closure and release
  assign loopEvent = loopDetected != loopPrev_q;
  assign gkeyEvent = gkeyDetected != gkeyPrev_q;
  assign loopRise  = loopDetected && !loopPrev_q;

  always_comb begin
    eventBits               = 2'h0;
    eventBits[IRQ_LOOP_BIT] = loopEvent;
    eventBits[IRQ_GKEY_BIT] = gkeyEvent;
  end

  assign wrPending = regWrite && regAddr == OFS_IRQ_PENDING;

  // Write one to clear; a same-cycle event keeps its bit set
  always_ff @(posedge clk) begin
    if (reset) begin
      irqPending_q <= 2'h0;
    end else begin
      irqPending_q <= ((wrPending ? irqPending_q & ~regWrData[1:0]
                                  : irqPending_q)
                       | (eventBits & irqEnable_q));
    end
  end

  assign irqRequest = |irqPending_q;

  // ---------------------------------------------------------------
  // Linefeed state and automatic transition
  // ---------------------------------------------------------------
  assign wrLinefeed = regWrite && regAddr == OFS_LINEFEED;

  // A software write in the same cycle wins over the automatic move
  always_ff @(posedge clk) begin
    if (reset) begin
      lineState_q <= LF_OPEN;
    end else if (wrLinefeed) begin
      lineState_q <= regWrData[LF_CTRL_LSB +: 3];
    end else if (loopRise && lineState_q == LF_TIP_OPEN) begin
      lineState_q <= LF_FWD_ACTIVE;
    end else if (loopRise && lineState_q == LF_RING_OPEN) begin
      lineState_q <= LF_REV_ACTIVE;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      loopLpf_q      <= RST_LPF;
      loopOffHook_q  <= RST_LOOP_OFFHK;
      loopOnHook_q   <= RST_LOOP_ONHK;
      loopDebounce_q <= RST_INTERVAL;
      loopMask_q     <= RST_INTERVAL;
      gkeyLpf_q      <= RST_LPF;
      gkeyHigh_q     <= RST_GKEY_HITH;
      gkeyLow_q      <= RST_GKEY_LOTH;
      gkeyDebounce_q <= RST_INTERVAL;
      cmThreshold_q  <= RST_CM_THRESHOLD;
      irqEnable_q    <= RST_IRQ_ENABLE;
    end else if (regWrite) begin
      unique case (regAddr)
        OFS_LOOP_LPF:     loopLpf_q      <= regWrData;
        OFS_LOOP_OFFHK:   loopOffHook_q  <= regWrData;
        OFS_LOOP_ONHK:    loopOnHook_q   <= regWrData;
        OFS_LOOP_DBI:     loopDebounce_q <= regWrData;
        OFS_LOOP_MASK:    loopMask_q     <= regWrData;
        OFS_GKEY_LPF:     gkeyLpf_q      <= regWrData;
        OFS_GKEY_HITH:    gkeyHigh_q     <= regWrData;
        OFS_GKEY_LOTH:    gkeyLow_q      <= regWrData;
        OFS_GKEY_DBI:     gkeyDebounce_q <= regWrData;
        OFS_CM_THRESHOLD: cmThreshold_q  <= regWrData;
        OFS_IRQ_ENABLE:   irqEnable_q    <= regWrData[1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  // Status and current registers are read only; writes are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_q <= 16'h0000;
    end else if (regRead) begin
      rdData_q <= 16'h0000;
      unique case (regAddr)
        OFS_LINEFEED: begin
          rdData_q[LF_CTRL_LSB +: 3]   <= lineState_q;
          rdData_q[LF_SHADOW_LSB +: 3] <= lineState_q;
        end
        OFS_DETECT_STATUS: begin
          rdData_q[STAT_CMH_BIT]  <= cmHigh_q;
          rdData_q[STAT_LOOP_BIT] <= loopDetected;
          rdData_q[STAT_GKEY_BIT] <= gkeyDetected;
        end
        OFS_IRQ_PENDING:  rdData_q[1:0] <= irqPending_q;
        OFS_IRQ_ENABLE:   rdData_q[1:0] <= irqEnable_q;
        OFS_LOOP_CURRENT: rdData_q <= loopCurrent_q;
        OFS_LONG_CURRENT: rdData_q <= longCurrent_q;
        OFS_LOOP_LPF:     rdData_q <= loopLpf_q;
        OFS_LOOP_OFFHK:   rdData_q <= loopOffHook_q;
        OFS_LOOP_ONHK:    rdData_q <= loopOnHook_q;
        OFS_LOOP_DBI:     rdData_q <= loopDebounce_q;
        OFS_LOOP_MASK:    rdData_q <= loopMask_q;
        OFS_GKEY_LPF:     rdData_q <= gkeyLpf_q;
        OFS_GKEY_HITH:    rdData_q <= gkeyHigh_q;
        OFS_GKEY_LOTH:    rdData_q <= gkeyLow_q;
        OFS_GKEY_DBI:     rdData_q <= gkeyDebounce_q;
        OFS_CM_THRESHOLD: rdData_q <= cmThreshold_q;
        default: ;
      endcase
    end
  end

  assign regRdData          = rdData_q;
  assign linefeedState      = lineState_q;
  assign loopClosureFlag    = loopDetected;
  assign groundKeyFlag      = gkeyDetected;
  assign commonModeHighFlag = cmHigh_q;

endmodule

// [loop_detector_monitor.sv]
// Port-level checker for the loop detector
module loop_detector_monitor
  import loop_detect_pkg::*;
(
  // Watched ports
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        sampleValid,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdData,
  input wire logic [2:0]  linefeedState,
  input wire logic        loopClosureFlag,
  input wire logic        groundKeyFlag,
  input wire logic        commonModeHighFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // Linefeed writes and automatic move
  // ---------------------------------------------------------------
  wire lfWr = regWrite && regAddr == OFS_LINEFEED;
  sequence s_rise_in(logic [2:0] st);
    $rose(loopClosureFlag) && linefeedState == st && !lfWr;
  endsequence
  a_tip_to_fwd: assert property (s_rise_in(LF_TIP_OPEN) |=>
    linefeedState == LF_FWD_ACTIVE) else $error("no move to forward");
  a_ring_to_rev: assert property (s_rise_in(LF_RING_OPEN) |=>
    linefeedState == LF_REV_ACTIVE) else $error("no move to reverse");
  a_lf_write: assert property (lfWr |=>
    linefeedState == $past(regWrData[2:0])) else $error("linefeed write lost");
  a_lf_hold: assert property (!lfWr && !$rose(loopClosureFlag) |=>
    $stable(linefeedState)) else $error("linefeed moved alone");
  // ---------------------------------------------------------------
  // Register port and flags
  // ---------------------------------------------------------------
  a_read_unmapped: assert property (regRead && regAddr == 8'h30 |=>
    regRdData == 16'h0000) else $error("unmapped read not zero");
  a_read_stands: assert property (!regRead |=> $stable(regRdData))
    else $error("read data moved");
  a_status_read: assert property (regRead &&
    regAddr == OFS_DETECT_STATUS |=> regRdData == {13'h0000,
    $past(groundKeyFlag), $past(loopClosureFlag), $past(commonModeHighFlag)})
    else $error("status read wrong");
  a_cmh_sample: assert property ($changed(commonModeHighFlag) |->
    $past(sampleValid)) else $error("common-mode flag without sample");
endmodule

bind loop_detector loop_detector_monitor mon (.clk(clk), .reset(reset),
  .sampleValid(sampleValid), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .linefeedState(linefeedState), .loopClosureFlag(loopClosureFlag),
  .groundKeyFlag(groundKeyFlag), .commonModeHighFlag(commonModeHighFlag));

// [tb_top.sv]
// Register-level test of the loop detector
module tb_top
  import loop_detect_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, regWrite = 0, regRead = 0, sampleValid, gk, lc;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000, regRdData, q1Level = 16'h0000;
  logic signed [15:0] currentQ1, otherQ;
  logic [2:0] linefeedState;
  logic common_mode_high_flag, irqRequest, ringEnd = 0;
  int fails = 0, n_compared = 0;
  initial forever #50 clk = ~clk;
  current_feed feed (.clk(clk), .reset(reset), .q1Level(q1Level),
    .sampleValid(sampleValid), .currentQ1(currentQ1), .otherQ(otherQ));
  loop_detector #(.STEP_CYCLES(4)) dut (.clk(clk), .reset(reset),
    .sampleValid(sampleValid), .currentQ1(currentQ1), .currentQ2(otherQ),
    .currentQ5(otherQ), .currentQ6(otherQ), .ringBurstEnd(ringEnd),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .linefeedState(linefeedState),
    .loopClosureFlag(lc), .groundKeyFlag(gk), .commonModeHighFlag(common_mode_high_flag),
    .irqRequest(irqRequest));
  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk) {regWrite, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clk) regWrite <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge clk) {regRead, regAddr} <= {1'b1, a};
    @(posedge clk) regRead <= 1'b0;
    #1 cmp(regRdData, exp);
  endtask
  task automatic wrap_up();
    $display("fails %0d n_compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_LOOP_LPF, RST_LPF);
    rd(OFS_LOOP_OFFHK, RST_LOOP_OFFHK);
    rd(OFS_IRQ_ENABLE, 16'h0000);
    rd(8'h30, 16'h0000);
    // Unity coefficients let each sample reach the comparators at once
    wr(OFS_LOOP_LPF, COEF_UNITY);
    wr(OFS_GKEY_LPF, COEF_UNITY);
    wr(OFS_IRQ_ENABLE, 16'h0003);
    wr(OFS_LINEFEED, 16'h0003);
    q1Level <= 16'h1800;
    repeat (12) @(posedge clk);
    rd(OFS_LOOP_CURRENT, 16'h1800);
    rd(OFS_LONG_CURRENT, 16'h0C00);
    cmp(lc, 1'b0);
    for (int i = 0; i < 300 && lc !== 1'b1; i++) @(posedge clk);
    cmp(gk, 1'b1);
    repeat (20) @(posedge clk);
    rd(OFS_LINEFEED, 16'h0011);
    rd(OFS_LOOP_CURRENT, 16'h0C00);
    rd(OFS_LONG_CURRENT, 16'h0000);
    for (int i = 0; i < 300 && gk !== 1'b0; i++) @(posedge clk);
    rd(OFS_IRQ_PENDING, 16'h0003);
    cmp(irqRequest, 1'b1);
    wr(OFS_IRQ_PENDING, 16'h0003);
    #1 cmp(irqRequest, 1'b0);
    // Large Q1 raises common mode; the next sample drops the Q1 term
    q1Level <= 16'h5000;
    repeat (20) @(posedge clk);
    cmp(common_mode_high_flag, 1'b1);
    rd(OFS_LOOP_CURRENT, 16'h0000);
    cmp(lc, 1'b1);
    q1Level <= 16'h0000;
    for (int i = 0; i < 300 && lc !== 1'b0; i++) @(posedge clk);
    cmp(lc, 1'b0);
    wr(OFS_LINEFEED, 16'h0007);
    // Burst end holds the loop debounce for eight steps before it can count
    @(posedge clk) {ringEnd, q1Level} <= {1'b1, 16'h1800};
    @(posedge clk) ringEnd <= 1'b0;
    repeat (50) @(posedge clk);
    cmp(lc, 1'b0);
    for (int i = 0; i < 300 && lc !== 1'b1; i++) @(posedge clk);
    rd(OFS_LINEFEED, 16'h0055);
    // Held closure would stay on the on-hook threshold unless disabled
    wr(OFS_LOOP_OFFHK, 16'h4CF1);
    for (int i = 0; i < 300 && lc !== 1'b0; i++) @(posedge clk);
    cmp(lc, 1'b0);
    wrap_up();
  end
  initial begin
    #1000000 fails++;
    wrap_up();
  end
endmodule
